//--- src/mms_defs.svh
// Constants of the measurement slave: framing, timing, map, codes.
// Assumes inclusion by its bare name from the package and the top.
// Contract
// - Serial link runs 19200 baud, eight data bits, no parity, one stop bit.
// - Slave address defaults to the last two decimal serial digits.
// - A valid request is answered within one second.
// - No extra delay is inserted before the reply starts.
// - Frames are separated by seven silent character times on both sides.
// - Values are read with function 03; the reply carries 03 too.
// - 32-bit values go out as byte1, byte0, byte3, byte2.
// - Floats keep sign/exponent/mantissa; 16-bit high byte first; 8-bit in low.
// - Flow float at 6, consumption 8, reverse 14, direction 42.
// - Direction reads 0 for normal flow and 1 for reversed flow.
// - Only one polling message is served at a time.
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH
`define MMS_CLK_HZ 250000000
`define MMS_BAUD 19200
`define MMS_CHAR_BITS 10
`define MMS_DATA_BITS 4'h8
`define MMS_STOP_BIT 4'h9
`define MMS_GAP_CHARS 7
`define MMS_RESP_TIME_MS 1000
`define MMS_MS_PER_S 1000
`define MMS_CRC_INIT 16'hffff
`define MMS_CRC_POLY 16'ha001
`define MMS_FC_READ 8'h03
`define MMS_FC_EXC_BIT 8'h80
`define MMS_EXC_FUNC 8'h01
`define MMS_EXC_ADDR 8'h02
`define MMS_EXC_QTY 8'h03
`define MMS_MAX_QTY 16'h007d
`define MMS_REQ_LEN 4'h8
`define MMS_MIN_LEN 4'h4
`define MMS_NB_SAT 4'hf
`define MMS_EXC_LEN 8'h05
`define MMS_OVH_LEN 8'h05
`define MMS_HDR_LEN 8'h03
`define MMS_B_ADDR 8'h00
`define MMS_B_FC 8'h01
`define MMS_B_CNT 8'h02
`define MMS_REG_FLOW 16'h0006
`define MMS_REG_TOTAL 16'h0008
`define MMS_REG_REV 16'h000e
`define MMS_REG_DIR 16'h002a
`define MMS_REG_SPAN 16'h0001
`define MMS_DEC_TEN 8'h0a
`endif

//--- src/mms_pkg.sv
// Types of the measurement slave: state, samples and line carriers.
// Assumes mms_defs.svh sits beside it.
package mms_pkg;
  `include "mms_defs.svh"

  typedef enum logic [1:0] {
    MMS_IDLE = 2'b00,
    MMS_TX = 2'b01
  } mms_st_t;

  typedef struct packed {
    logic [31:0] flow;
    logic [31:0] total;
    logic [31:0] reverse;
    logic dir;
  } mms_meas_t;

  typedef struct packed {
    logic txd;
    logic de;
  } mms_line_t;

  typedef struct packed {
    logic [2:0] sync;
    logic rx_lvl;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [3:0] nbytes;
    logic bad;
    logic [15:0] rx_crc;
    logic [19:0] gap;
    logic [63:0] rxb;
    mms_st_t st;
    logic exc;
    logic [7:0] fcode;
    logic [7:0] exc_code;
    logic [15:0] start;
    logic [7:0] len;
    logic [7:0] idx;
    logic [8:0] tx_sh;
    logic [3:0] tx_bitn;
    logic [15:0] tx_cnt;
    logic [15:0] tx_crc;
    logic [27:0] resp;
    mms_meas_t snap;
    logic [7:0] addr;
    logic addr_ok;
    mms_line_t line;
    logic served;
    logic dropped;
  } mms_state_t;
endpackage

//--- src/mms_slave.sv
// RTU read-holding-register slave serving four measurement channels.
// Assumes an RS-485 transceiver outside; line idles high.
`timescale 1ns/1ps
`include "mms_defs.svh"
module mms_slave #(
  parameter int BIT_CYCLES = `MMS_CLK_HZ / `MMS_BAUD,
  parameter int GAP_CYCLES = BIT_CYCLES * `MMS_CHAR_BITS * `MMS_GAP_CHARS,
  parameter int RESP_CYCLES = `MMS_CLK_HZ / `MMS_MS_PER_S * `MMS_RESP_TIME_MS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial line
  input wire logic i_rxd,
  output mms_pkg::mms_line_t o_line,
  // Address strap, decimal digits
  input wire logic [3:0] i_serial_tens,
  input wire logic [3:0] i_serial_ones,
  // Measurements
  input mms_pkg::mms_meas_t i_meas,
  // Status
  output logic [7:0] o_slave_addr,
  output logic o_busy,
  output logic o_served,
  output logic o_dropped
);
  import mms_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] mms_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MMS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Low word at the base register, high word above it
  function automatic logic [15:0] mms_word(input mms_meas_t m, input logic [15:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a == `MMS_REG_FLOW) begin
      w = m.flow[15:0];
    end else if (a == `MMS_REG_FLOW + `MMS_REG_SPAN) begin
      w = m.flow[31:16];
    end else if (a == `MMS_REG_TOTAL) begin
      w = m.total[15:0];
    end else if (a == `MMS_REG_TOTAL + `MMS_REG_SPAN) begin
      w = m.total[31:16];
    end else if (a == `MMS_REG_REV) begin
      w = m.reverse[15:0];
    end else if (a == `MMS_REG_REV + `MMS_REG_SPAN) begin
      w = m.reverse[31:16];
    end else if (a == `MMS_REG_DIR) begin
      w = {15'h0000, m.dir};
    end
    return w;
  endfunction

  // Byte at the transmit index; word sent high byte first
  function automatic logic [7:0] mms_tx_byte(input mms_state_t s);
    logic [7:0] k;
    logic [15:0] w;
    k = s.idx - `MMS_HDR_LEN;
    w = mms_word(s.snap, s.start + {9'h000, k[7:1]});
    if (s.idx == s.len - 8'h02) begin
      return s.tx_crc[7:0];
    end else if (s.idx == s.len - 8'h01) begin
      return s.tx_crc[15:8];
    end else if (s.idx == `MMS_B_ADDR) begin
      return s.addr;
    end else if (s.idx == `MMS_B_FC) begin
      return s.exc ? (s.fcode | `MMS_FC_EXC_BIT) : `MMS_FC_READ;
    end else if (s.idx == `MMS_B_CNT) begin
      return s.exc ? s.exc_code : s.len - `MMS_OVH_LEN;
    end
    return k[0] ? w[7:0] : w[15:8];
  endfunction

  function automatic logic mms_in(input logic [15:0] lo, input logic [15:0] a,
                                  input logic [16:0] e);
    return (a >= lo) && (e <= {1'b0, lo + `MMS_REG_SPAN});
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam mms_state_t MMS_RST = '{sync: 3'b111, rx_lvl: 1'b1,
    rx_crc: `MMS_CRC_INIT, tx_crc: `MMS_CRC_INIT, st: MMS_IDLE,
    line: '{txd: 1'b1, de: 1'b0}, default: '0};

  mms_state_t s_q;
  mms_state_t s_d;
  logic frame_end;
  logic accept;
  logic hit;
  logic [15:0] qty;
  logic [15:0] st_reg;
  logic [16:0] last;
  logic [7:0] fc;

  always_comb begin
    s_d = s_q;
    frame_end = 1'b0;
    accept = 1'b0;
    s_d.served = 1'b0;
    s_d.dropped = 1'b0;
    fc = s_q.rxb[15:8];
    st_reg = {s_q.rxb[23:16], s_q.rxb[31:24]};
    qty = {s_q.rxb[39:32], s_q.rxb[47:40]};
    last = {1'b0, st_reg} + {1'b0, qty} - 17'h00001;
    hit = (s_q.rx_crc == 16'h0000) && !s_q.bad && (s_q.nbytes >= `MMS_MIN_LEN)
      && s_q.addr_ok && (s_q.rxb[7:0] == s_q.addr);
    // Three-stage sampling, change taken when the last two agree
    s_d.sync = {s_q.sync[1:0], i_rxd};
    if (s_q.sync[2] == s_q.sync[1]) begin
      s_d.rx_lvl = s_q.sync[1];
    end
    // Address caught once after reset release
    if (!s_q.addr_ok) begin
      s_d.addr = 8'({4'h0, i_serial_tens} * `MMS_DEC_TEN) + {4'h0, i_serial_ones};
      s_d.addr_ok = 1'b1;
    end
    // Receiver; deaf while replying, one message at a time
    if (s_q.st == MMS_TX) begin
      s_d.rx_busy = 1'b0;
      s_d.gap = 20'h00000;
      s_d.nbytes = 4'h0;
      s_d.bad = 1'b0;
      s_d.rx_crc = `MMS_CRC_INIT;
    end else if (!s_q.rx_busy) begin
      if (!s_q.rx_lvl) begin
        s_d.rx_busy = 1'b1;
        s_d.rx_cnt = 16'(BIT_CYCLES / 2);
        s_d.rx_bit = 4'h0;
      end else begin
        if (s_q.gap != 20'(GAP_CYCLES)) begin
          s_d.gap = s_q.gap + 20'h00001;
        end
        frame_end = (s_q.gap == 20'(GAP_CYCLES - 1)) && (s_q.nbytes != 4'h0);
      end
    end else if (s_q.rx_cnt != 16'h0000) begin
      s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
    end else begin
      // Mid-bit sampling of 8N1 characters
      s_d.rx_cnt = 16'(BIT_CYCLES - 1);
      s_d.rx_bit = s_q.rx_bit + 4'h1;
      if (s_q.rx_bit == 4'h0 && s_q.rx_lvl) begin
        s_d.rx_busy = 1'b0;
      end else if (s_q.rx_bit <= `MMS_DATA_BITS) begin
        s_d.rx_sh = {s_q.rx_lvl, s_q.rx_sh[7:1]};
      end else begin
        s_d.rx_busy = 1'b0;
        s_d.gap = 20'h00000;
        if (!s_q.rx_lvl) begin
          s_d.bad = 1'b1;
        end else begin
          if (s_q.nbytes < `MMS_REQ_LEN) begin
            s_d.rxb[{s_q.nbytes[2:0], 3'b000} +: 8] = s_q.rx_sh;
          end
          if (s_q.nbytes != `MMS_NB_SAT) begin
            s_d.nbytes = s_q.nbytes + 4'h1;
          end
          s_d.rx_crc = mms_crc(s_q.rx_crc, s_q.rx_sh);
        end
      end
    end
    // Frame decision as soon as the gap closes
    if (frame_end) begin
      s_d.nbytes = 4'h0;
      s_d.bad = 1'b0;
      s_d.rx_crc = `MMS_CRC_INIT;
      s_d.exc = 1'b1;
      s_d.fcode = fc;
      s_d.len = `MMS_EXC_LEN;
      s_d.start = st_reg;
      if (!hit) begin
        s_d.dropped = 1'b1;
      end else if (fc != `MMS_FC_READ) begin
        s_d.exc_code = `MMS_EXC_FUNC;
        accept = 1'b1;
      end else if (s_q.nbytes != `MMS_REQ_LEN) begin
        s_d.dropped = 1'b1;
      end else if (qty == 16'h0000 || qty > `MMS_MAX_QTY) begin
        s_d.exc_code = `MMS_EXC_QTY;
        accept = 1'b1;
      end else if (!(mms_in(`MMS_REG_FLOW, st_reg, last - 17'h00002)
          || mms_in(`MMS_REG_TOTAL, st_reg, last)
          || mms_in(`MMS_REG_REV, st_reg, last)
          || mms_in(`MMS_REG_DIR, st_reg, last))) begin
        // Partial word pairs allowed; gaps between channels refused
        s_d.exc_code = `MMS_EXC_ADDR;
        accept = 1'b1;
      end else begin
        s_d.exc = 1'b0;
        s_d.len = `MMS_OVH_LEN + {qty[6:0], 1'b0};
        accept = 1'b1;
      end
    end
    case (s_q.st)
      MMS_IDLE: begin
        if (accept) begin
          // Reply starts next cycle; values frozen for a coherent read
          s_d.st = MMS_TX;
          s_d.idx = 8'h00;
          s_d.tx_bitn = 4'h0;
          s_d.tx_cnt = 16'h0000;
          s_d.tx_crc = `MMS_CRC_INIT;
          s_d.resp = 28'h0000000;
          s_d.snap = i_meas;
          s_d.line.de = 1'b1;
        end
      end
      MMS_TX: begin
        s_d.resp = s_q.resp + 28'h0000001;
        if (s_q.tx_cnt != 16'h0000) begin
          s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
        end else if (s_q.tx_bitn != 4'h0) begin
          s_d.line.txd = s_q.tx_sh[0];
          s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]};
          s_d.tx_bitn = s_q.tx_bitn - 4'h1;
          s_d.tx_cnt = 16'(BIT_CYCLES - 1);
        end else if (s_q.idx == s_q.len) begin
          s_d.st = MMS_IDLE;
          s_d.line = '{txd: 1'b1, de: 1'b0};
          s_d.served = 1'b1;
        end else begin
          s_d.line.txd = 1'b0;
          s_d.tx_sh = {1'b1, mms_tx_byte(s_q)};
          s_d.tx_bitn = `MMS_STOP_BIT;
          s_d.tx_cnt = 16'(BIT_CYCLES - 1);
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.idx < s_q.len - 8'h02) begin
            s_d.tx_crc = mms_crc(s_q.tx_crc, mms_tx_byte(s_q));
          end
        end
        // Watchdog: a reply never outlasts the response time
        if (s_q.resp == 28'(RESP_CYCLES - 1)) begin
          s_d.st = MMS_IDLE;
          s_d.line = '{txd: 1'b1, de: 1'b0};
        end
      end
      default: begin
        s_d.st = MMS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= MMS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_line = s_q.line;
  assign o_slave_addr = s_q.addr;
  assign o_busy = (s_q.st == MMS_TX);
  assign o_served = s_q.served;
  assign o_dropped = s_q.dropped;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_idle_high;
    @(posedge i_clk) disable iff (!rst_n) !s_q.line.de |-> s_q.line.txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");

  property p_addr;
    @(posedge i_clk) disable iff (!rst_n) s_q.addr_ok |->
      s_q.addr == 8'(i_serial_tens * `MMS_DEC_TEN + i_serial_ones);
  endproperty
  a_addr: assert property (p_addr) else $error("slave address wrong");

  property p_quick;
    @(posedge i_clk) disable iff (!rst_n) accept |=> s_q.line.de && s_q.st == MMS_TX;
  endproperty
  a_quick: assert property (p_quick) else $error("reply not started");

  property p_bounded;
    @(posedge i_clk) disable iff (!rst_n) s_q.st == MMS_TX |-> s_q.resp < 28'(RESP_CYCLES);
  endproperty
  a_bounded: assert property (p_bounded) else $error("reply too long");

  property p_gap;
    @(posedge i_clk) disable iff (!rst_n) $rose(s_q.line.de) |->
      $past(s_q.gap) == 20'(GAP_CYCLES - 1);
  endproperty
  a_gap: assert property (p_gap) else $error("reply before gap");

  property p_fc;
    @(posedge i_clk) disable iff (!rst_n)
      s_q.st == MMS_TX && !s_q.exc && s_q.idx == `MMS_B_FC && s_q.tx_bitn == 4'h0
      && s_q.tx_cnt == 16'h0000 |=> s_q.tx_sh[7:0] == `MMS_FC_READ;
  endproperty
  a_fc: assert property (p_fc) else $error("wrong function code");

  property p_order;
    @(posedge i_clk) disable iff (!rst_n) $changed(s_q.idx) && s_q.idx == `MMS_HDR_LEN + 8'h01
      && !s_q.exc && s_q.start == `MMS_REG_TOTAL |-> s_q.tx_sh[7:0] == s_q.snap.total[15:8];
  endproperty
  a_order: assert property (p_order) else $error("word order wrong");

  property p_dir;
    @(posedge i_clk) disable iff (!rst_n) $changed(s_q.idx) && s_q.idx == `MMS_HDR_LEN + 8'h02
      && !s_q.exc && s_q.start == `MMS_REG_DIR |-> s_q.tx_sh[7:0] == {7'h00, s_q.snap.dir};
  endproperty
  a_dir: assert property (p_dir) else $error("direction value wrong");

  property p_drop;
    @(posedge i_clk) disable iff (!rst_n) frame_end && !hit |=> !s_q.line.de [*2];
  endproperty
  a_drop: assert property (p_drop) else $error("bad frame answered");

  property p_single;
    @(posedge i_clk) disable iff (!rst_n) s_q.st == MMS_TX |-> !frame_end && !s_q.rx_busy;
  endproperty
  a_single: assert property (p_single) else $error("second message taken");
endmodule

//--- tb/mms_master.sv
// Master model for the measurement slave: sends RTU requests, gathers replies.
// Assumes the bench shares its clock and calls the tasks one at a time.
`timescale 1ns/1ps
module mms_master #(
  parameter int BIT_CYCLES = 8,
  parameter int GAP_CYCLES = 560
) (
  // Clock
  input wire logic i_clk,
  // Serial line
  output logic o_rxd,
  input mms_pkg::mms_line_t i_line
);
  import mms_pkg::*;
  logic [7:0] rx_q[$];
  logic tmo;
  int lat;
  initial begin
    o_rxd = 1'b1;
    tmo = 1'b0;
    lat = 0;
  end
  // ------
  // Framing
  // ------
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction
  // Spoil flips CRC bits so a refusal can be provoked
  task automatic send(input logic [7:0] f[$], input logic [7:0] spoil);
    logic [15:0] c;
    logic [9:0] ch;
    c = crc16(f);
    f.push_back(c[7:0] ^ spoil);
    f.push_back(c[15:8]);
    repeat (GAP_CYCLES) @(negedge i_clk);
    foreach (f[i]) begin
      ch = {1'b1, f[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        o_rxd = ch[b];
        repeat (BIT_CYCLES) @(negedge i_clk);
      end
    end
  endtask
  // Bounded wait per start bit; a bad stop bit also sets tmo
  task automatic collect(input int nb);
    int n;
    logic [7:0] b;
    rx_q.delete();
    tmo = 1'b0;
    for (int k = 0; k < nb && !tmo; k++) begin
      n = 0;
      while (i_line.txd !== 1'b0 && n < GAP_CYCLES + 16 * BIT_CYCLES) begin
        @(negedge i_clk);
        n++;
      end
      if (k == 0) lat = n;
      tmo = (n >= GAP_CYCLES + 16 * BIT_CYCLES);
      repeat (BIT_CYCLES / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(negedge i_clk);
        b[i] = i_line.txd;
      end
      repeat (BIT_CYCLES) @(negedge i_clk);
      if (i_line.txd !== 1'b1 || i_line.de !== 1'b1) tmo = 1'b1;
      rx_q.push_back(b);
    end
  endtask
endmodule

//--- tb/mms_slave_test.sv
// Self-checking bench for the measurement slave over its RTU line.
// Assumes the master model is compiled first; shortened bit and gap counts.
`timescale 1ns/1ps
module mms_slave_test;
  import mms_pkg::*;
  localparam int BIT = 8;
  localparam int GAP = BIT * 70;
  logic i_clk;
  logic i_rst_n;
  logic rxd;
  mms_line_t line;
  logic [3:0] tens;
  logic [3:0] ones;
  mms_meas_t meas;
  logic [7:0] slave_addr;
  logic busy;
  logic served;
  logic dropped;
  int error_cnt;
  int checked;

  mms_slave #(.BIT_CYCLES(BIT), .GAP_CYCLES(GAP), .RESP_CYCLES(20000)) dut_u (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rxd(rxd),
    .o_line(line),
    .i_serial_tens(tens),
    .i_serial_ones(ones),
    .i_meas(meas),
    .o_slave_addr(slave_addr),
    .o_busy(busy),
    .o_served(served),
    .o_dropped(dropped)
  );
  mms_master #(.BIT_CYCLES(BIT), .GAP_CYCLES(GAP)) master_u (
    .i_clk(i_clk),
    .o_rxd(rxd),
    .i_line(line)
  );

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ------
  // Helpers
  // ------
  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  // Two-register read of one 32-bit channel, reply checked byte by byte
  task automatic rd(input logic [15:0] base, input logic [31:0] v);
    logic [7:0] q[$];
    logic [7:0] r[$];
    logic [15:0] c;
    logic seen;
    q = '{8'h2a, 8'h03, base[15:8], base[7:0], 8'h00, 8'h02};
    master_u.send(q, 8'h00);
    master_u.collect(9);
    chk("framing", 0, master_u.tmo);
    if (master_u.tmo) wrap_up();
    r = master_u.rx_q;
    chk("lat_low", 1, master_u.lat >= GAP - BIT);
    chk("lat_high", 1, master_u.lat <= GAP + 8);
    chk("head", {8'h00, 8'h2a, 8'h03, 8'h04}, {8'h00, r[0], r[1], r[2]});
    chk("data", {v[15:8], v[7:0], v[31:24], v[23:16]}, {r[3], r[4], r[5], r[6]});
    chk("msb_view", v, {r[5], r[6], r[3], r[4]});
    chk("lsb_view", {v[7:0], v[15:8], v[23:16], v[31:24]}, {r[4], r[3], r[6], r[5]});
    c = master_u.crc16(r[0:6]);
    chk("crc", {16'h0000, c}, {16'h0000, r[8], r[7]});
    seen = 1'b0;
    for (int n = 0; n < 2 * BIT && !seen; n++) begin
      @(negedge i_clk);
      seen = served;
    end
    chk("served", 1, seen);
    @(negedge i_clk);
    chk("busy_after", 0, busy);
  endtask
  // Frame that must be refused: no driver enable, one drop pulse
  task automatic drop(input logic [7:0] a, input logic [7:0] spoil);
    logic [7:0] q[$];
    logic seen;
    logic talk;
    q = '{a, 8'h03, 8'h00, 8'h06, 8'h00, 8'h02};
    master_u.send(q, spoil);
    seen = 1'b0;
    talk = 1'b0;
    repeat (GAP + 16 * BIT) begin
      @(negedge i_clk);
      seen = seen | dropped;
      talk = talk | line.de;
    end
    chk("dropped", 1, seen);
    chk("silent", 0, talk);
  endtask
  // Refused request that still earns an exception reply
  task automatic exc(input logic [7:0] fc, input logic [15:0] base, input logic [15:0] n,
                     input logic [7:0] code);
    logic [7:0] q[$];
    logic [7:0] r[$];
    logic [15:0] c;
    q = '{8'h2a, fc, base[15:8], base[7:0], n[15:8], n[7:0]};
    master_u.send(q, 8'h00);
    master_u.collect(5);
    chk("exc_framing", 0, master_u.tmo);
    if (master_u.tmo) wrap_up();
    r = master_u.rx_q;
    chk("exc_head", {8'h2a, fc | 8'h80, code}, {r[0], r[1], r[2]});
    c = master_u.crc16(r[0:2]);
    chk("exc_crc", {16'h0000, c}, {16'h0000, r[4], r[3]});
    repeat (2 * BIT) @(negedge i_clk);
    chk("exc_busy", 0, busy);
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    i_rst_n = 1'b0;
    tens = 4'h4;
    ones = 4'h2;
    meas = '{32'h4128_3c5a, 32'h1234_5678, 32'h0a0b_0c0d, 1'b0};
    error_cnt = 0;
    checked = 0;
    repeat (12) @(negedge i_clk);
    chk("idle_line", 32'h0000_0002, {30'h0, line.txd, line.de});
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("slave_addr", 32'h0000_002a, {24'h0, slave_addr});
    rd(16'h0006, meas.flow);
    rd(16'h0008, meas.total);
    rd(16'h000e, meas.reverse);
    rd(16'h002a, 32'h0000_0000);
    meas.dir = 1'b1;
    rd(16'h002a, 32'h0000_0001);
    drop(8'h2b, 8'h00);
    drop(8'h2a, 8'h01);
    exc(8'h04, 16'h0006, 16'h0002, 8'h01);
    exc(8'h03, 16'h0000, 16'h0002, 8'h02);
    exc(8'h03, 16'h0008, 16'h0000, 8'h03);
    rd(16'h0008, meas.total);
    wrap_up();
  end
endmodule
